// ### core/rivp_vector_place.sv
// Notes on behaviour
// R01: all resets go to 0x000 if fuse unprogrammed
// R02: programmed fuse starts at boot reset address
// R03: fuse 1 unprogrammed, 0 programmed
// R04: select bit moves table to boot section
// R05: relocated vector equals offset plus boot start
// R06: select clear: vectors start at 0x001
// R07: external requests zero/one at 0x001, 0x002
// R08: pin-change 0x003-0x005, watchdog at 0x006
// R09: second 8-bit timer at 0x007-0x009
// R10: 16-bit timer at 0x00a-0x00d
// R11: first 8-bit timer at 0x00e-0x010
// R12: serial sources at 0x011-0x014
// R13: adc..program-store ready at 0x015-0x019
// R14: unused vectors may hold code (software)
// R15: split sections free vectors (software)
// R16: lowest pending vector number wins
`timescale 1ns/1ps
`include "rivp_defines.svh"

module rivp_vector_place #(
  parameter int                      NUM_SRC    = `RIVP_NUM_SRC,
  parameter logic [`RIVP_ADDR_W-1:0] BOOT_START = `RIVP_BOOT_START
) (
  input  wire logic                      clock,
  input  wire logic                      resetn,
  input  wire logic                      boot_reset_select_fuse,
  input  wire logic                      vector_table_boot_select,
  input  wire logic [NUM_SRC-1:0]        irq_pending,
  input  wire logic                      irq_ack,
  output rivp_pkg::rivp_pc_load_t        pc_load,
  output logic [`RIVP_ADDR_W-1:0]        reset_addr,
  output logic [`RIVP_ADDR_W-1:0]        vector_start
);

  ////////////////////////////////////////////////////////////////////////
  // fuse level synchroniser

  logic [2:0] fuse_sync;
  logic [2:0] next_fuse_sync;
  logic       fuse_level;
  logic       next_fuse_level;

  // the fuse sense line is not timed to this clock; three stages,
  // and a change counts only once the second and third agree
  always_comb
  begin
    next_fuse_sync  = {fuse_sync[1:0], boot_reset_select_fuse};
    next_fuse_level = fuse_level;
    if (fuse_sync[1] == fuse_sync[2])
      next_fuse_level = fuse_sync[2];                          // R03
  end

  // no reset here: the level must have settled while reset is held,
  // so the reset load right after release already sees the fuse
  always_ff @(posedge clock)
  begin
    fuse_sync  <= next_fuse_sync;
    fuse_level <= next_fuse_level;
  end

  ////////////////////////////////////////////////////////////////////////
  // placement decode, purely from fuse and select bit

  logic                    fuse_programmed;
  logic [`RIVP_ADDR_W-1:0] next_reset_addr;
  logic [`RIVP_ADDR_W-1:0] next_vector_start;
  logic [`RIVP_ADDR_W-1:0] table_base;

  // fuse is active low: 0 means programmed
  always_comb
  begin
    fuse_programmed = (fuse_level == `RIVP_FUSE_PROG);         // R03
    if (fuse_programmed)
      next_reset_addr = BOOT_START;                            // R02
    else
      next_reset_addr = `RIVP_RESET_ADDR;                      // R01
    // table base is independent of the fuse
    if (vector_table_boot_select)
      table_base = BOOT_START;                                 // R04
    else
      table_base = '0;                                         // R06
    next_vector_start = table_base + `RIVP_VEC_BASE;           // R05
  end

  ////////////////////////////////////////////////////////////////////////
  // priority pick: lowest index is the lowest vector number

  logic                    any_pend;
  logic [4:0]              pick;
  logic [`RIVP_ADDR_W-1:0] pick_addr;
  logic [NUM_SRC:0]        none_below;
  logic [NUM_SRC-1:0]      grant;
  logic [`RIVP_ADDR_W-1:0] vec_addr [NUM_SRC];

  // ripple chain: a source wins only if nothing below it is pending
  assign none_below[0] = 1'b1;

  // one entry per source: grant bit and its vector address
  generate
    for (genvar g = 0; g < NUM_SRC; g++)
    begin : g_src
      assign grant[g]        = irq_pending[g] && none_below[g];     // R16
      assign none_below[g+1] = none_below[g] && !irq_pending[g];
      // source n sits one word above n-1, table starts at offset 1
      assign vec_addr[g] = next_vector_start + `RIVP_ADDR_W'(g);
    end                                                 // R07 R08 R09 R10
  endgenerate

  // grant is one-hot, so the encoder needs no priority of its own
  always_comb
  begin
    any_pend  = !none_below[NUM_SRC];                          // R16
    pick      = '0;
    pick_addr = '0;
    for (int i = 0; i < NUM_SRC; i++)
    begin
      if (grant[i])
      begin
        pick      = 5'(i);
        pick_addr = vec_addr[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // core load sequencing: reset load first, then one load per ack

  typedef enum logic [1:0] {
    RIVP_ST_RESET = 2'b10,
    RIVP_ST_IDLE  = 2'b01,
    RIVP_ST_WAIT  = 2'b11
  } rivp_state_t;

  rivp_state_t             state;
  rivp_state_t             next_state;
  rivp_pkg::rivp_pc_load_t next_pc_load;

  // a new load is offered only after the core acks the last one,
  // so a request that rises mid-wait cannot swap the address
  always_comb
  begin
    next_state   = state;
    next_pc_load = pc_load;
    next_pc_load.load = 1'b0;
    case (state)
      RIVP_ST_RESET:
      begin
        next_pc_load.load     = 1'b1;                          // R01
        next_pc_load.is_reset = 1'b1;
        next_pc_load.src      = '0;
        next_pc_load.addr     = next_reset_addr;               // R02
        next_state            = RIVP_ST_WAIT;
      end
      RIVP_ST_IDLE:
      begin
        if (any_pend)
        begin
          next_pc_load.load     = 1'b1;                        // R16
          next_pc_load.is_reset = 1'b0;
          next_pc_load.src      = pick;
          next_pc_load.addr     = pick_addr;                   // R11 R12 R13
          next_state            = RIVP_ST_WAIT;
        end
      end
      RIVP_ST_WAIT:
      begin
        next_pc_load.load = !irq_ack;
        if (irq_ack)
          next_state = RIVP_ST_IDLE;
      end
      default:
        next_state = RIVP_ST_RESET;
    endcase
  end

  // registers only
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      state        <= RIVP_ST_RESET;
      pc_load      <= '0;
      reset_addr   <= `RIVP_RESET_ADDR;
      vector_start <= `RIVP_VEC_BASE;
    end
    else
    begin
      state        <= next_state;
      pc_load      <= next_pc_load;
      reset_addr   <= next_reset_addr;
      vector_start <= next_vector_start;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  // reset load right after release, address from the raw fuse level
  chk_reset_target: assert property ( // R01
    @(posedge clock) disable iff (!resetn)
    $rose(resetn) |=> pc_load.load && pc_load.is_reset &&
      pc_load.addr == (boot_reset_select_fuse ? 12'h000 : BOOT_START))
    else $error("reset load address wrong");

  chk_fuse_sense: assert property ( // R03
    @(posedge clock) disable iff (!resetn)
    fuse_level == `RIVP_FUSE_PROG |=> reset_addr == BOOT_START)
    else $error("programmed fuse not seen");

  chk_fuse_unprog: assert property ( // R01
    @(posedge clock) disable iff (!resetn)
    fuse_level == `RIVP_FUSE_UNPROG |=> reset_addr == 12'h000)
    else $error("unprogrammed fuse reset address wrong");

  // the reset state is left on the first edge out of reset
  chk_boot_reset: assert property ( // R02
    @(posedge clock) disable iff (!resetn)
    state == RIVP_ST_RESET && fuse_level == `RIVP_FUSE_PROG |=>
      pc_load.load && pc_load.addr == BOOT_START)
    else $error("boot reset load address wrong");

  chk_reset_match: assert property ( // R02
    @(posedge clock) disable iff (!resetn)
    pc_load.load && pc_load.is_reset |-> pc_load.addr == reset_addr)
    else $error("reset load differs from reset address");

  chk_vec_start: assert property ( // R06
    @(posedge clock) disable iff (!resetn)
    !vector_table_boot_select |=> vector_start == 12'h001)
    else $error("vector start not 0x001");

  chk_vec_reloc: assert property ( // R04
    @(posedge clock) disable iff (!resetn)
    vector_table_boot_select |=> vector_start == BOOT_START + 12'h001)
    else $error("relocated start wrong");

  chk_lowest_wins: assert property ( // R16
    @(posedge clock) disable iff (!resetn)
    state == RIVP_ST_IDLE && irq_pending[0] |=>
      pc_load.load && pc_load.src == 5'h00)
    else $error("lowest source not picked");

  chk_grant_single: assert property ( // R16
    @(posedge clock) disable iff (!resetn)
    $onehot0(grant))
    else $error("more than one source granted");

  chk_idle_quiet: assert property ( // R16
    @(posedge clock) disable iff (!resetn)
    state == RIVP_ST_IDLE && irq_pending == '0 |=> !pc_load.load)
    else $error("load offered with nothing pending");

  // the select bit must not move under a load that is being checked
  chk_vec_offset: assert property ( // R07
    @(posedge clock) disable iff (!resetn)
    pc_load.load && !pc_load.is_reset && !vector_table_boot_select &&
      $stable(vector_table_boot_select) |->
      pc_load.addr == 12'(pc_load.src) + 12'h001)
    else $error("vector offset wrong");

  chk_reloc_offset: assert property ( // R05
    @(posedge clock) disable iff (!resetn)
    pc_load.load && !pc_load.is_reset && vector_table_boot_select &&
      $stable(vector_table_boot_select) |->
      pc_load.addr == BOOT_START + 12'(pc_load.src) + 12'h001)
    else $error("relocated vector offset wrong");

  chk_src_range: assert property ( // R13
    @(posedge clock) disable iff (!resetn)
    pc_load.load && !pc_load.is_reset |-> pc_load.src < 5'(NUM_SRC))
    else $error("source index out of range");

  chk_load_holds: assert property ( // R16
    @(posedge clock) disable iff (!resetn)
    pc_load.load && !irq_ack |=> pc_load.load && $stable(pc_load.addr))
    else $error("load dropped before ack");

  chk_wait_load: assert property ( // R16
    @(posedge clock) disable iff (!resetn)
    state == RIVP_ST_WAIT |-> pc_load.load)
    else $error("wait state without a load");

  chk_ack_ends: assert property ( // R16
    @(posedge clock) disable iff (!resetn)
    pc_load.load && irq_ack |=> !pc_load.load)
    else $error("load not ended by ack");

endmodule

// ### core/rivp_defines.svh
`ifndef RIVP_DEFINES_SVH
`define RIVP_DEFINES_SVH
// word address width of the program counter load
`define RIVP_ADDR_W      12
// number of interrupt sources (vectors 2..26)
`define RIVP_NUM_SRC     25
// reset vector with the boot-reset fuse unprogrammed
`define RIVP_RESET_ADDR  12'h000
// first interrupt vector offset in the base table
`define RIVP_VEC_BASE    12'h001
// fuse levels
`define RIVP_FUSE_UNPROG 1'b1
`define RIVP_FUSE_PROG   1'b0
// default boot section start, word address
`define RIVP_BOOT_START  12'hc00
`endif

// ### core/rivp_pkg.sv
package rivp_pkg;
  // source index: bit n vectors to base offset n+1
  typedef enum logic [4:0] {
    RIVP_SRC_EXT0 = 5'h00, RIVP_SRC_EXT1 = 5'h01,
    RIVP_SRC_PC0  = 5'h02, RIVP_SRC_PC1  = 5'h03,
    RIVP_SRC_PC2  = 5'h04, RIVP_SRC_WDOG = 5'h05,
    RIVP_SRC_T2CA = 5'h06, RIVP_SRC_T2CB = 5'h07,
    RIVP_SRC_T2OV = 5'h08, RIVP_SRC_T1CP = 5'h09,
    RIVP_SRC_T1CA = 5'h0a, RIVP_SRC_T1CB = 5'h0b,
    RIVP_SRC_T1OV = 5'h0c, RIVP_SRC_T0CA = 5'h0d,
    RIVP_SRC_T0CB = 5'h0e, RIVP_SRC_T0OV = 5'h0f,
    RIVP_SRC_SPI  = 5'h10, RIVP_SRC_URX  = 5'h11,
    RIVP_SRC_UDRE = 5'h12, RIVP_SRC_UTX  = 5'h13,
    RIVP_SRC_ADC  = 5'h14, RIVP_SRC_EERD = 5'h15,
    RIVP_SRC_ACMP = 5'h16, RIVP_SRC_TWS  = 5'h17,
    RIVP_SRC_SPMR = 5'h18
  } rivp_src_t;

  // program-counter load toward the core
  typedef struct packed {
    logic        load;
    logic        is_reset;
    logic [4:0]  src;
    logic [11:0] addr;
  } rivp_pc_load_t;
endpackage

// ### tb/rivp_core_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module rivp_core_model (
  input  wire logic              clock,
  input  wire logic              resetn,
  input  rivp_pkg::rivp_pc_load_t pc_load,
  input  wire logic [24:0]       set_mask,
  input  wire logic [3:0]        ack_delay,
  output logic [24:0]            irq_pending,
  output logic                   irq_ack
);
  logic [3:0] wait_cnt;

  // flags stay up until their vector is taken, as real sources do
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      irq_pending <= 25'h0000000;
      irq_ack     <= 1'b0;
      wait_cnt    <= 4'h0;
    end
    else
    begin
      irq_pending <= irq_pending | set_mask;
      irq_ack     <= 1'b0;
      wait_cnt    <= 4'h0;
      // slow core: ack only after ack_delay+1 cycles of load
      if (pc_load.load && !irq_ack)
      begin
        wait_cnt <= wait_cnt + 4'h1;
        irq_ack  <= (wait_cnt >= ack_delay);
      end
      if (pc_load.load && irq_ack && !pc_load.is_reset)
        irq_pending[pc_load.src] <= 1'b0;
    end
  end
endmodule

// ### tb/tb.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module tb;
  localparam logic [11:0] BOOT = 12'hc00;
  logic                    clock;
  logic                    resetn;
  logic                    fuse;
  logic                    vsel;
  logic [24:0]             set_mask;
  logic [24:0]             pending;
  logic [3:0]              ack_delay;
  logic                    irq_ack;
  rivp_pkg::rivp_pc_load_t pc_load;
  logic [11:0]             reset_addr;
  logic [11:0]             vector_start;
  int                      miscompares;
  int                      checks_done;

  rivp_vector_place #(.NUM_SRC(25), .BOOT_START(BOOT)) dut_u (
    .clock(clock), .resetn(resetn), .boot_reset_select_fuse(fuse),
    .vector_table_boot_select(vsel), .irq_pending(pending),
    .irq_ack(irq_ack), .pc_load(pc_load), .reset_addr(reset_addr),
    .vector_start(vector_start));
  rivp_core_model core_u (
    .clock(clock), .resetn(resetn), .pc_load(pc_load),
    .set_mask(set_mask), .ack_delay(ack_delay),
    .irq_pending(pending), .irq_ack(irq_ack));

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [11:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic do_reset(input logic f, input logic s);
    @(posedge clock);
    resetn <= 1'b0;
    fuse   <= f;
    vsel   <= s;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
  endtask

  task automatic raise(input logic [24:0] m);
    @(posedge clock);
    set_mask <= m;
    @(posedge clock);
    set_mask <= 25'h0;
  endtask

  // address must hold steady for the whole wait on a slow core
  task automatic take(input logic [11:0] e, input logic rst);
    int n;
    n = 0;
    while (pc_load.load !== 1'b1 && n < 40)
    begin
      @(negedge clock);
      n++;
    end
    check("is_reset", {11'h0, rst}, {11'h0, pc_load.is_reset});
    while (pc_load.load === 1'b1 && n < 40)
    begin
      check("pc_load addr", e, pc_load.addr);
      @(negedge clock);
      n++;
    end
    if (n >= 40)
    begin
      miscompares++;
      print_verdict();
    end
  endtask

  ////////////////////////////////////////////////////////////
  // all four fuse/select pairs, every source under each
  task automatic s_placement;
    logic [11:0] base;
    for (int k = 0; k < 4; k++)
    begin
      do_reset(k[1], k[0]);
      take(k[1] ? 12'h000 : BOOT, 1'b1);
      base = k[0] ? BOOT : 12'h000;
      check("vector_start", base + 12'h001, vector_start);
      check("reset_addr", k[1] ? 12'h000 : BOOT, reset_addr);
      for (int i = 0; i < 25; i++)
      begin
        raise(25'h1 << i);
        take(base + 12'h001 + 12'(i), 1'b0);
        check("pc_load src", 12'(i), {7'h0, pc_load.src});
      end
    end
  endtask

  task automatic s_priority;
    @(posedge clock);
    ack_delay <= 4'h5;
    raise(25'h0100008);
    take(BOOT + 12'h004, 1'b0);
    take(BOOT + 12'h015, 1'b0);
    @(posedge clock);
    vsel      <= 1'b0;
    ack_delay <= 4'h0;
    repeat (3) @(posedge clock);
    @(negedge clock);
    check("vector_start", 12'h001, vector_start);
  endtask

  initial
  begin
    resetn      = 1'b0;
    fuse        = 1'b1;
    vsel        = 1'b0;
    set_mask    = 25'h0;
    ack_delay   = 4'h0;
    miscompares = 0;
    checks_done = 0;
    s_placement();
    s_priority();
    print_verdict();
  end
endmodule
